/* File: rtl/aimrd_pkg.sv */
// package: constants, encodings and carrier types for the input mux and reference decoder
package aimrd_pkg;

    // configuration word layout
    localparam int CFG_WIDTH     = 14;
    localparam int CFG_UPD_POS   = 13;
    localparam int INCC_MSB      = 12;
    localparam int INCC_LSB      = 10;
    localparam int CHAN_MSB      = 9;
    localparam int CHAN_LSB      = 7;
    localparam int BW_POS        = 6;
    localparam int REFSEL_MSB    = 5;
    localparam int REFSEL_LSB    = 3;
    localparam int SEQ_MSB       = 2;
    localparam int SEQ_LSB       = 1;
    localparam int RB_POS        = 0;
    localparam logic [13:0] CFG_RESET = 14'h3fff;

    // serial shift counter
    localparam int BITCNT_WIDTH = 4;
    localparam logic [3:0] BITCNT_LAST = 4'hd;

    // apb register map (byte addresses)
    localparam int ADDR_WIDTH = 12;
    localparam logic [11:0] OFS_CFG_PEND   = 12'h000;
    localparam logic [11:0] OFS_CFG_ACTIVE = 12'h004;
    localparam logic [11:0] OFS_CTRL       = 12'h008;
    localparam logic [11:0] OFS_STATUS     = 12'h00c;
    localparam int CTRL_TEMP_POS = 0;
    localparam logic CTRL_TEMP_RESET = 1'b0;

    // input configuration codes
    localparam logic [2:0] INCC_SINGLE_GND = 3'h7;
    localparam logic [2:0] INCC_COM_BIP    = 3'h2;
    localparam logic [2:0] INCC_COM_GND    = 3'h6;
    localparam logic [1:0] INCC_PAIR_BIP   = 2'h0;
    localparam logic [1:0] INCC_PAIR_UNI   = 2'h2;

    // reference scheme codes
    localparam logic [2:0] REF_INT_2V5      = 3'h0;
    localparam logic [2:0] REF_INT_4V096    = 3'h1;
    localparam logic [2:0] REF_EXT_BUF_TEMP = 3'h2;
    localparam logic [2:0] REF_EXT_DIR_TEMP = 3'h3;
    localparam logic [2:0] REF_EXT_DIR      = 3'h6;
    localparam logic [2:0] REF_EXT_BUF      = 3'h7;

    typedef enum logic [1:0] {
        neg_gnd,
        neg_com,
        neg_pair
    } aimrd_neg_kind_type;

    typedef struct packed {
        logic [2:0]         pos_ch;
        aimrd_neg_kind_type neg_kind;
        logic [2:0]         neg_ch;
        logic               bipolar;
        logic               binary_code;
        logic               filter_bandwidth_bit;
        logic               int_ref_en;
        logic               int_ref_4v096;
        logic               ref_buf_en;
        logic               temp_sensor_en;
        logic               temp_selected;
    } aimrd_decode_type;

    typedef struct packed {
        logic [31:0] paddr_dummy_unused_none;
    } aimrd_unused_type;

    // decode of the reset word: channel 7 against ground, unipolar, buffer only
    localparam aimrd_decode_type DECODE_RESET = '{
        pos_ch:               3'h7,
        neg_kind:             neg_gnd,
        neg_ch:               3'h0,
        bipolar:              1'b0,
        binary_code:          1'b1,
        filter_bandwidth_bit: 1'b1,
        int_ref_en:           1'b0,
        int_ref_4v096:        1'b0,
        ref_buf_en:           1'b1,
        temp_sensor_en:       1'b0,
        temp_selected:        1'b0
    };

    // whole module state
    typedef struct packed {
        logic             sck_s1;
        logic             sck_s2;
        logic             sck_s3;
        logic             sdi_s1;
        logic             sdi_s2;
        logic             csn_s1;
        logic             csn_s2;
        logic [13:0]      shift;
        logic [3:0]       bit_cnt;
        logic [13:0]      pend;
        logic [13:0]      active;
        logic             temp_measure;
        aimrd_decode_type dec;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } aimrd_state_type;

endpackage

/* File: rtl/aimrd_top.sv */
// module: configuration word capture and input mux / reference decode with apb access
`timescale 1ns/100ps

module aimrd_top (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    cfg_sck,
    input  wire logic                    cfg_sdi,
    input  wire logic                    cfg_sel_n,
    input  wire logic                    conv_done,
    input  wire logic                    seq_active,
    input  wire logic [2:0]              seq_ch,
    output aimrd_pkg::aimrd_decode_type  decoded
);

    aimrd_pkg::aimrd_state_type state;
    aimrd_pkg::aimrd_state_type next_state;

    logic        sck_rise;
    logic        wr_take;
    logic        rd_setup;
    logic        addr_ok;
    logic [13:0] shifted;

    // reference, buffer and sensor enables for one reference code
    function automatic aimrd_pkg::aimrd_decode_type decode_reference(
        input aimrd_pkg::aimrd_decode_type din,
        input logic [2:0]                  refsel
    );
        aimrd_pkg::aimrd_decode_type d;
        d                = din;
        d.int_ref_en     = 1'b0;
        d.int_ref_4v096  = 1'b0;
        d.ref_buf_en     = 1'b0;
        d.temp_sensor_en = 1'b0;
        case (refsel)
            aimrd_pkg::REF_INT_2V5: begin
                d.int_ref_en = 1'b1;
                d.ref_buf_en = 1'b1;
            end
            aimrd_pkg::REF_INT_4V096: begin
                d.int_ref_en    = 1'b1;
                d.int_ref_4v096 = 1'b1;
                d.ref_buf_en    = 1'b1;
            end
            aimrd_pkg::REF_EXT_BUF_TEMP: begin
                d.ref_buf_en     = 1'b1;
                d.temp_sensor_en = 1'b1;
            end
            aimrd_pkg::REF_EXT_DIR_TEMP: begin
                // bandgap kept on only to feed the sensor
                d.int_ref_en = 1'b1;
            end
            aimrd_pkg::REF_EXT_BUF: begin
                d.ref_buf_en = 1'b1;
            end
            default: begin
                // direct external reference and spare codes: all off
                d.ref_buf_en = 1'b0;
            end
        endcase
        // the sensor runs whenever the bandgap runs
        if (d.int_ref_en) begin
            d.temp_sensor_en = 1'b1;
        end
        return d;
    endfunction

    // input mux, polarity and coding decode of one configuration word
    function automatic aimrd_pkg::aimrd_decode_type decode_word(
        input logic [13:0] cfg,
        input logic        use_seq,
        input logic [2:0]  seq_sel,
        input logic        temp_sel
    );
        aimrd_pkg::aimrd_decode_type d;
        logic [2:0]                  incc;
        logic [2:0]                  ch;
        incc = cfg[aimrd_pkg::INCC_MSB:aimrd_pkg::INCC_LSB];
        ch   = use_seq ? seq_sel : cfg[aimrd_pkg::CHAN_MSB:aimrd_pkg::CHAN_LSB];
        d    = '0;
        // 111 and the spare 011: single-ended against ground, unipolar
        d.pos_ch   = ch;
        d.neg_kind = aimrd_pkg::neg_gnd;
        d.neg_ch   = 3'h0;
        d.bipolar  = 1'b0;
        if (incc == aimrd_pkg::INCC_COM_BIP) begin
            d.neg_kind = aimrd_pkg::neg_com;
            d.bipolar  = 1'b1;
        end else if (incc == aimrd_pkg::INCC_COM_GND) begin
            d.neg_kind = aimrd_pkg::neg_com;
        end else if (incc[2:1] == aimrd_pkg::INCC_PAIR_BIP
                     || incc[2:1] == aimrd_pkg::INCC_PAIR_UNI) begin
            // code lsb ignored: adjacent pairs, partner is the sense input
            d.neg_kind = aimrd_pkg::neg_pair;
            d.bipolar  = (incc[2:1] == aimrd_pkg::INCC_PAIR_BIP);
            if (use_seq) begin
                d.pos_ch = {ch[2:1], 1'b0};
            end
            d.neg_ch = {d.pos_ch[2:1], ~d.pos_ch[0]};
        end
        d.filter_bandwidth_bit = cfg[aimrd_pkg::BW_POS];
        d.temp_selected        = temp_sel;
        d.binary_code          = ~d.bipolar | temp_sel;
        d = decode_reference(d, cfg[aimrd_pkg::REFSEL_MSB:aimrd_pkg::REFSEL_LSB]);
        return d;
    endfunction

    // next-state logic for the whole block
    always_comb begin
        next_state = state;

        // pin synchronisers, two flops before use
        next_state.sck_s1 = cfg_sck;
        next_state.sck_s2 = state.sck_s1;
        next_state.sck_s3 = state.sck_s2;
        next_state.sdi_s1 = cfg_sdi;
        next_state.sdi_s2 = state.sdi_s1;
        next_state.csn_s1 = cfg_sel_n;
        next_state.csn_s2 = state.csn_s1;

        // serial capture, msb first, 14 rising clock edges
        sck_rise = state.sck_s2 & ~state.sck_s3;
        shifted  = {state.shift[12:0], state.sdi_s2};
        if (state.csn_s2) begin
            next_state.bit_cnt = '0;
        end else if (sck_rise && state.bit_cnt <= aimrd_pkg::BITCNT_LAST) begin
            next_state.shift   = shifted;
            next_state.bit_cnt = state.bit_cnt + 4'h1;
            if (state.bit_cnt == aimrd_pkg::BITCNT_LAST) begin
                next_state.pend = shifted;
            end
        end

        // apb decode: no wait state, answer prepared in setup
        addr_ok  = (paddr == aimrd_pkg::OFS_CFG_PEND)
                 | (paddr == aimrd_pkg::OFS_CFG_ACTIVE)
                 | (paddr == aimrd_pkg::OFS_CTRL)
                 | (paddr == aimrd_pkg::OFS_STATUS);
        rd_setup = psel & ~penable;
        wr_take  = psel & penable & state.pready & pwrite & addr_ok;
        next_state.pready  = rd_setup;
        next_state.pslverr = rd_setup & ~addr_ok;
        next_state.prdata  = '0;
        if (rd_setup && !pwrite) begin
            case (paddr)
                aimrd_pkg::OFS_CFG_PEND:   next_state.prdata = {18'h0_0000, state.pend};
                aimrd_pkg::OFS_CFG_ACTIVE: next_state.prdata = {18'h0_0000, state.active};
                aimrd_pkg::OFS_CTRL: begin
                    next_state.prdata = {31'h0000_0000, state.temp_measure};
                end
                aimrd_pkg::OFS_STATUS: begin
                    next_state.prdata = {27'h000_0000, ~state.csn_s2, state.bit_cnt};
                end
                default: next_state.prdata = '0;
            endcase
        end

        // software writes; a completed serial word wins over an apb write
        if (wr_take && paddr == aimrd_pkg::OFS_CFG_PEND
            && !(sck_rise && !state.csn_s2 && state.bit_cnt == aimrd_pkg::BITCNT_LAST)) begin
            next_state.pend = pwdata[13:0];
        end
        if (wr_take && paddr == aimrd_pkg::OFS_CTRL) begin
            next_state.temp_measure = pwdata[aimrd_pkg::CTRL_TEMP_POS];
        end

        // pending word takes effect only at end of conversion
        if (conv_done) begin
            next_state.active = state.pend;
            next_state.dec    = decode_word(state.pend, seq_active, seq_ch,
                                            state.temp_measure);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= '0;
            state.csn_s1       <= 1'b1;
            state.csn_s2       <= 1'b1;
            state.pend         <= aimrd_pkg::CFG_RESET;
            state.active       <= aimrd_pkg::CFG_RESET;
            state.temp_measure <= aimrd_pkg::CTRL_TEMP_RESET;
            state.dec          <= aimrd_pkg::DECODE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign prdata  = state.prdata;
    assign pready  = state.pready;
    assign pslverr = state.pslverr;
    assign decoded = state.dec;

endmodule // aimrd_top

/* File: verification/aimrd_assertions.sv */
// checker: decode relations and apb ready on the top module outputs
`timescale 1ns/100ps
module aimrd_checker (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pready,
    input wire logic                        conv_done,
    input wire logic                        seq_active,
    input wire logic [2:0]                  seq_ch,
    input wire aimrd_pkg::aimrd_decode_type decoded
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hold; !conv_done |=> $stable(decoded); endproperty
    a_hold: assert property (p_hold) else $error("decode moved");
    property p_ref4; decoded.int_ref_4v096 |-> decoded.int_ref_en; endproperty
    a_ref4: assert property (p_ref4) else $error("4v096 without ref");
    property p_temp; decoded.int_ref_en |-> decoded.temp_sensor_en; endproperty
    a_temp: assert property (p_temp) else $error("sensor off");
    property p_pair; decoded.neg_kind == aimrd_pkg::neg_pair
        |-> decoded.neg_ch == {decoded.pos_ch[2:1], ~decoded.pos_ch[0]}; endproperty
    a_pair: assert property (p_pair) else $error("bad partner");
    property p_seq; conv_done && seq_active |=> {decoded.pos_ch[2:1], 1'b0} ==
        ($past(seq_ch) & 3'h6) && (decoded.neg_kind != aimrd_pkg::neg_pair
        || !decoded.pos_ch[0]); endproperty
    a_seq: assert property (p_seq) else $error("bad sequencer pick");
    property p_code; decoded.binary_code == (!decoded.bipolar || decoded.temp_selected);
    endproperty
    a_code: assert property (p_code) else $error("bad coding");
    property p_tbin; decoded.temp_selected |-> decoded.binary_code; endproperty
    a_tbin: assert property (p_tbin) else $error("temp not binary");
    property p_gnd; decoded.neg_kind == aimrd_pkg::neg_gnd |-> !decoded.bipolar; endproperty
    a_gnd: assert property (p_gnd) else $error("ground bipolar");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
endmodule // aimrd_checker

/* File: verification/aimrd_cfg_host.sv */
// partner: host shifting a configuration word into the serial pins
`timescale 1ns/100ps
module aimrd_cfg_host (
    input wire logic        pclk,
    input wire logic        go,
    input wire logic [3:0]  half,
    input wire logic [13:0] word,
    output logic            sck,
    output logic            sdi,
    output logic            sel_n,
    output logic            busy
);
    // one frame: select, 14 clocks msb first, release; sck idles low
    initial begin
        {sck, sdi, sel_n, busy} = 4'h2;
        forever begin
            @(posedge pclk);
            if (go && !busy) begin
                busy  <= 1'b1;
                sel_n <= 1'b0;
                for (int i = 13; i >= 0; i--) begin
                    sdi <= word[i];
                    repeat (half) @(posedge pclk);
                    sck <= 1'b1;
                    repeat (half) @(posedge pclk);
                    sck <= 1'b0;
                end
                repeat (half) @(posedge pclk);
                sel_n <= 1'b1;
                sdi   <= ~word[0]; // stale data not left on the line
                busy  <= 1'b0;
            end
        end
    end
endmodule // aimrd_cfg_host

/* File: verification/tb.sv */
// testbench: apb, serial and conversion stimulus with decode checks
`timescale 1ns/100ps
module tb;
    logic                        pclk = 1'b0;
    logic                        presetn, psel, penable, pwrite, conv_done;
    logic                        seq_active, go, pready, pslverr, sck, sdi, sel_n, busy, serr;
    logic [11:0]                 paddr;
    logic [31:0]                 pwdata, prdata, q;
    logic [2:0]                  seq_ch;
    logic [3:0]                  half;
    logic [13:0]                 word;
    aimrd_pkg::aimrd_decode_type decoded;
    int                          error_cnt, n_compared;

    always #5 pclk = ~pclk;
    aimrd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cfg_sck(sck), .cfg_sdi(sdi), .cfg_sel_n(sel_n), .conv_done,
        .seq_active, .seq_ch, .decoded);
    aimrd_cfg_host host_u (.pclk, .go, .half, .word, .sck, .sdi, .sel_n, .busy);

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait for a level, timing out into the report
    task automatic wait_lvl(ref logic s, input logic v);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (s !== v && k < 400);
        if (s !== v) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_lvl(pready, 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conv;
        @(posedge pclk);
        conv_done <= 1'b1;
        @(posedge pclk);
        conv_done <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset;
        apb(0, aimrd_pkg::OFS_CFG_ACTIVE, 32'h0);
        chk("active", 32'h0000_3fff, q);
        chk("buf", 32'h1, decoded.ref_buf_en);
        apb(0, 12'h010, 32'h0);
        chk("slverr", 32'h1, serr);
        chk("unmapped", 32'h0, q);
        $display("reset done");
    endtask
    // every input code, channel stepping through both parities
    task automatic t_inputs;
        logic [2:0] cd [8] = '{3'h7, 3'h2, 3'h6, 3'h0, 3'h1, 3'h4, 3'h5, 3'h3};
        logic [2:0] c;
        logic       pr;
        for (int i = 0; i < 8; i++) begin
            c = cd[i];
            pr = (c[2:1] == 2'h0 || c[2:1] == 2'h2);
            apb(1, aimrd_pkg::OFS_CFG_PEND, {18'h0, 1'h1, c, i[2:0], 7'h7f});
            chk("hold", (i == 0) ? 32'h7 : i - 1, decoded.pos_ch);
            conv();
            chk("kind", pr ? 2 : (c == 3'h7 || c == 3'h3 ? 0 : 1), decoded.neg_kind);
            chk("bw_full", 32'h1, decoded.filter_bandwidth_bit);
            chk("bip", c == 3'h2 || c[2:1] == 2'h0, decoded.bipolar);
            chk("neg", pr ? i ^ 1 : 0, decoded.neg_ch);
        end
        seq_active <= 1'b1;
        seq_ch <= 3'h5;
        apb(1, aimrd_pkg::OFS_CFG_PEND, 32'h0000_02ff);
        conv();
        chk("seqpos", 32'h4, decoded.pos_ch);
        seq_active <= 1'b0;
        $display("inputs done");
    endtask
    task automatic t_ref;
        logic [2:0] r [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};
        logic [3:0] e [8] = '{4'hb, 4'hf, 4'h3, 4'h9, 4'h0, 4'h2, 4'h0, 4'h0};
        for (int i = 0; i < 8; i++) begin
            apb(1, aimrd_pkg::OFS_CFG_PEND, {18'h0, 8'hff, r[i], 3'h7});
            conv();
            chk("ref", e[i], {decoded.int_ref_en, decoded.int_ref_4v096, decoded.ref_buf_en,
                decoded.temp_sensor_en});
        end
        $display("reference done");
    endtask
    task automatic frame(input logic [3:0] h, input logic [13:0] w);
        @(posedge pclk);
        half <= h;
        word <= w;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        wait_lvl(busy, 1'b0);
        apb(0, aimrd_pkg::OFS_CFG_PEND, 32'h0);
        chk("pend", {18'h0, w}, q);
    endtask
    // serial load, then temperature and bandwidth on a bipolar word
    task automatic t_serial;
        frame(4'h8, 14'h2a55);
        frame(4'h4, 14'h098f);
        apb(1, aimrd_pkg::OFS_CTRL, 32'h1);
        apb(0, aimrd_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", 32'h1, q);
        conv();
        chk("bw", 32'h0, decoded.filter_bandwidth_bit);
        chk("tbin", 32'h3, {decoded.bipolar, decoded.binary_code});
        chk("tsel", 32'h1, decoded.temp_selected);
        apb(1, aimrd_pkg::OFS_CTRL, 32'h0);
        conv();
        chk("twos", 32'h0, decoded.binary_code);
        apb(0, aimrd_pkg::OFS_CFG_ACTIVE, 32'h0);
        chk("active", 32'h0000_098f, q);
        apb(0, aimrd_pkg::OFS_STATUS, 32'h0);
        chk("status", 32'h0, q);
        $display("serial done");
    endtask

    initial begin
        {presetn, psel, penable, pwrite, conv_done, seq_active, go} = 7'h0;
        {paddr, pwdata, seq_ch, half, word} = '0;
        error_cnt = 0;
        n_compared = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_inputs();
        t_ref();
        t_serial();
        tally_and_finish();
    end
endmodule // tb

bind aimrd_top aimrd_checker chk_u (.pclk, .presetn, .psel, .penable, .pready, .conv_done,
    .seq_active, .seq_ch, .decoded);
